// File: ptm_pkg.sv
// package: register map, field positions and reset values of the periodic timer
package ptm_pkg;
	localparam int CNT_W = 10;
	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_CTRL0    = 8'h00;
	localparam logic [7:0] ADDR_CTRL1    = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO   = 8'h08;
	localparam logic [7:0] ADDR_CNT_HI   = 8'h0c;
	localparam logic [7:0] ADDR_CMPA_LO  = 8'h10;
	localparam logic [7:0] ADDR_CMPA_HI  = 8'h14;
	localparam logic [7:0] ADDR_PER_LO   = 8'h18;
	localparam logic [7:0] ADDR_PER_HI   = 8'h1c;
	localparam logic [7:0] ADDR_FLAGS    = 8'h20;
	// control zero: counter_run bit
	localparam int CTRL0_RUN_BIT = 3;
	// timer_ctrl_one field positions
	localparam int C1_MODE_HI = 7;
	localparam int C1_MODE_LO = 6;
	localparam int C1_ACT_HI  = 5;
	localparam int C1_ACT_LO  = 4;
	localparam int C1_INIT    = 3;
	localparam int C1_INV     = 2;
	localparam int C1_CAPSRC  = 1;
	localparam int C1_CLRSRC  = 0;
	// flags register bits
	localparam int FLG_A_BIT = 0;
	localparam int FLG_P_BIT = 1;
	// reset values
	localparam logic [7:0]       CTRL1_RST = 8'h00;
	localparam logic [CNT_W-1:0] VAL_RST   = 10'h000;
	// operating modes
	typedef enum logic [1:0] {
		PTM_MODE_CMP  = 2'b00,
		PTM_MODE_CAP  = 2'b01,
		PTM_MODE_PWM  = 2'b10,
		PTM_MODE_TMR  = 2'b11
	} ptm_mode_t;
	// pin action codes
	localparam logic [1:0] ACT_NONE   = 2'b00;
	localparam logic [1:0] ACT_LOW    = 2'b01;
	localparam logic [1:0] ACT_HIGH   = 2'b10;
	localparam logic [1:0] ACT_TOGGLE = 2'b11;
endpackage

// File: ptm_edge_sync.sv
// two-flop pin synchroniser with rise and fall pulses
`timescale 1ns/10ps
`default_nettype none
module ptm_edge_sync (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// first flop feeds only the second one
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= pinIn;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// one pulse per qualifying edge
	assign level = sync_ff;
	assign rise  = sync_ff & ~prev_ff;
	assign fall  = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// File: ptm_timer.sv
// periodic timer: apb registers, 10-bit counter, comparators and modes
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ptm_timer (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic            pready,
	output logic [31:0]     prdata,
	output logic            pslverr,
	input  wire logic       timerPinIn,
	input  wire logic       timerClockPin,
	output logic            timerPinOut,
	output logic            timerPinOeN,
	output logic            timerIrq
);
	import ptm_pkg::*;

	logic                rstMeta_ff;
	logic                rstSync_ff;
	logic                rstN;
	logic [7:0]          ctrl1_ff;
	logic                run_ff;
	logic                runPrev_ff;
	logic [CNT_W-1:0]    cnt_ff;
	logic [CNT_W-1:0]    cmpA_ff;
	logic [CNT_W-1:0]    per_ff;
	logic                flagA_ff;
	logic                flagP_ff;
	logic                pinOut_ff;
	logic                irq_ff;
	logic                tpRise;
	logic                tpFall;
	logic                tcRise;
	logic                tcFall;
	ptm_mode_t           mode;
	logic [1:0]          act;
	logic                wrEn;
	logic                rdEn;
	logic                runRise;
	logic                matchA;
	logic                matchP;
	logic                overflow;
	logic                pulseMode;
	logic                pwmActive;
	logic                capEdge;
	logic                clrCnt;
	logic                setA;
	logic                setP;
	logic [CNT_W-1:0]    nxt_cnt;
	logic [10:0]         pwmPeriod;

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end
	assign rstN = rstSync_ff;

	// pin synchronisers
	ptm_edge_sync uSyncTp (
		.clk   (ref_clk),
		.rstN  (rstN),
		.pinIn (timerPinIn),
		.level (),
		.rise  (tpRise),
		.fall  (tpFall)
	);
	ptm_edge_sync uSyncTc (
		.clk   (ref_clk),
		.rstN  (rstN),
		.pinIn (timerClockPin),
		.level (),
		.rise  (tcRise),
		.fall  (tcFall)
	);

	// apb decode: zero-wait answer
	assign wrEn    = psel & penable & pwrite;
	assign rdEn    = psel & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// decoded fields
	assign mode      = ptm_mode_t'(ctrl1_ff[C1_MODE_HI:C1_MODE_LO]);
	assign act       = ctrl1_ff[C1_ACT_HI:C1_ACT_LO];
	assign pulseMode = (mode == PTM_MODE_PWM) && (act == ACT_TOGGLE);
	assign runRise   = run_ff & ~runPrev_ff;

	// comparators; period match one count early so a period spans exactly
	assign matchA   = run_ff && (cnt_ff == cmpA_ff);
	assign overflow = run_ff && (cnt_ff == {CNT_W{1'b1}});
	assign matchP   = run_ff && ((per_ff == VAL_RST) ? overflow
	                             : (cnt_ff == per_ff - 10'h001));

	// capture edge select
	always_comb begin
		logic r;
		logic f;
		r = ctrl1_ff[C1_CAPSRC] ? tcRise : tpRise;
		f = ctrl1_ff[C1_CAPSRC] ? tcFall : tpFall;
		case (act)
			2'b00:   capEdge = r;
			2'b01:   capEdge = f;
			2'b10:   capEdge = r | f;
			default: capEdge = 1'b0; // capture disabled
		endcase
		if (!(run_ff && mode == PTM_MODE_CAP)) begin
			capEdge = 1'b0;
		end
	end

	// clear source and flag events per mode
	always_comb begin
		clrCnt = 1'b0;
		setA   = 1'b0;
		setP   = 1'b0;
		case (mode)
			PTM_MODE_CMP, PTM_MODE_TMR: begin
				if (ctrl1_ff[C1_CLRSRC]) begin
					clrCnt = matchA;
					setA   = matchA;
				end else begin
					clrCnt = matchP;
					setA   = matchA;
					setP   = matchP;
				end
			end
			PTM_MODE_PWM: begin
				if (pulseMode) begin
					setA = matchA;
				end else begin
					clrCnt = matchP;
					setA   = matchA;
					setP   = matchP;
				end
			end
			PTM_MODE_CAP: begin
				clrCnt = matchP;
				setP   = matchP;
			end
			default: begin
				clrCnt = 1'b0;
			end
		endcase
	end

	// counter next value
	always_comb begin
		if (runRise) begin
			nxt_cnt = VAL_RST;
		end else if (!run_ff) begin
			nxt_cnt = cnt_ff; // residual kept
		end else if (clrCnt) begin
			nxt_cnt = VAL_RST;
		end else begin
			nxt_cnt = cnt_ff + 10'h001;
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			cnt_ff <= VAL_RST;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// control register writes
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			ctrl1_ff <= CTRL1_RST;
			per_ff   <= VAL_RST;
		end else if (wrEn) begin
			case (paddr)
				ADDR_CTRL1:  ctrl1_ff <= pwdata[7:0];
				ADDR_PER_LO: per_ff[7:0] <= pwdata[7:0];
				ADDR_PER_HI: per_ff[9:8] <= pwdata[1:0];
				default:     ctrl1_ff <= ctrl1_ff;
			endcase
		end
	end

	// compare-A: software write, capture load wins
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			cmpA_ff <= VAL_RST;
		end else if (capEdge) begin
			cmpA_ff <= cnt_ff;
		end else if (wrEn && paddr == ADDR_CMPA_LO) begin
			cmpA_ff[7:0] <= pwdata[7:0];
		end else if (wrEn && paddr == ADDR_CMPA_HI) begin
			cmpA_ff[9:8] <= pwdata[1:0];
		end
	end

	// counter_run: software, clock-pin trigger, match stop
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			run_ff     <= 1'b0;
			runPrev_ff <= 1'b0;
		end else begin
			runPrev_ff <= run_ff;
			if (pulseMode && run_ff && matchA) begin
				run_ff <= 1'b0;
			end else if (pulseMode && !run_ff && (tcRise | tcFall)) begin
				run_ff <= 1'b1;
			end else if (wrEn && paddr == ADDR_CTRL0) begin
				run_ff <= pwdata[CTRL0_RUN_BIT];
			end
		end
	end

	// sticky flags, write one to clear, set wins
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			flagA_ff <= 1'b0;
			flagP_ff <= 1'b0;
		end else begin
			flagA_ff <= setA | capEdge |
			            (flagA_ff & ~(wrEn && paddr == ADDR_FLAGS &&
			                          pwdata[FLG_A_BIT]));
			flagP_ff <= setP |
			            (flagP_ff & ~(wrEn && paddr == ADDR_FLAGS &&
			                          pwdata[FLG_P_BIT]));
		end
	end

	// timer interrupt pulse on any flag event
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= setA | setP | capEdge;
		end
	end
	assign timerIrq = irq_ff;

	// pwm period 1024 when period is zero; duty at or over period is full
	assign pwmPeriod = (per_ff == VAL_RST) ? 11'h400 : {1'b0, per_ff};
	assign pwmActive = ({1'b0, cmpA_ff} >= pwmPeriod) ||
	                   (cnt_ff < cmpA_ff);

	// output pin level
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			pinOut_ff <= 1'b0;
		end else if (mode == PTM_MODE_CMP) begin
			if (runRise) begin
				pinOut_ff <= ctrl1_ff[C1_INIT];
			end else if (setA) begin
				case (act)
					ACT_LOW:    pinOut_ff <= 1'b0;
					ACT_HIGH:   pinOut_ff <= 1'b1;
					ACT_TOGGLE: pinOut_ff <= ~pinOut_ff;
					default:    pinOut_ff <= pinOut_ff;
				endcase
			end
		end else if (mode == PTM_MODE_PWM) begin
			case (act)
				ACT_NONE: pinOut_ff <= ~ctrl1_ff[C1_INIT];
				ACT_LOW:  pinOut_ff <= ctrl1_ff[C1_INIT];
				ACT_HIGH: pinOut_ff <= (run_ff & pwmActive) ~^
				                       ctrl1_ff[C1_INIT];
				default:  pinOut_ff <= (nxt_cnt != cmpA_ff || runRise) &&
				                       run_ff && !(matchA) ?
				                       ctrl1_ff[C1_INIT] :
				                       ~ctrl1_ff[C1_INIT];
			endcase
		end else begin
			pinOut_ff <= 1'b0;
		end
	end

	// inversion applies in pwm and compare modes only
	assign timerPinOut = (mode == PTM_MODE_PWM || mode == PTM_MODE_CMP) ?
	                     pinOut_ff ^ ctrl1_ff[C1_INV] : 1'b0;
	assign timerPinOeN = !(mode == PTM_MODE_PWM ||
	                       mode == PTM_MODE_CMP);

	// read mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (rdEn) begin
			case (paddr)
				ADDR_CTRL0:   prdata[CTRL0_RUN_BIT] = run_ff;
				ADDR_CTRL1:   prdata[7:0] = ctrl1_ff;
				ADDR_CNT_LO:  prdata[7:0] = cnt_ff[7:0];
				ADDR_CNT_HI:  prdata[1:0] = cnt_ff[9:8];
				ADDR_CMPA_LO: prdata[7:0] = cmpA_ff[7:0];
				ADDR_CMPA_HI: prdata[1:0] = cmpA_ff[9:8];
				ADDR_PER_LO:  prdata[7:0] = per_ff[7:0];
				ADDR_PER_HI:  prdata[1:0] = per_ff[9:8];
				ADDR_FLAGS:   prdata[1:0] = {flagP_ff, flagA_ff};
				default:      prdata = 32'h0000_0000;
			endcase
		end
	end

	// checks
	AST_RUNRISE_CLR: assert property (@(posedge ref_clk) disable iff (!rstN)
		runRise |=> cnt_ff == VAL_RST)
		else $error("counter not zeroed on run rise");
	AST_RUNFALL_HOLD: assert property (@(posedge ref_clk) disable iff (!rstN)
		!run_ff && !runRise |=> $stable(cnt_ff))
		else $error("counter moved while stopped");
	AST_CLR_A_NOP: assert property (@(posedge ref_clk) disable iff (!rstN)
		(mode == PTM_MODE_CMP && ctrl1_ff[C1_CLRSRC] && run_ff) |-> !setP)
		else $error("flag P raised with clear source A");
	AST_PULSE_STOP: assert property (@(posedge ref_clk) disable iff (!rstN)
		(pulseMode && run_ff && matchA) |=> !run_ff)
		else $error("single pulse not stopped");
	AST_CAP_LOAD: assert property (@(posedge ref_clk) disable iff (!rstN)
		capEdge |=> cmpA_ff == $past(cnt_ff))
		else $error("capture value wrong");
	AST_CAP_OFF: assert property (@(posedge ref_clk) disable iff (!rstN)
		(mode == PTM_MODE_CAP && act == ACT_TOGGLE) |-> !capEdge)
		else $error("capture while disabled");
	AST_CMP_INIT: assert property (@(posedge ref_clk) disable iff (!rstN)
		(mode == PTM_MODE_CMP && runRise) |=>
		pinOut_ff == $past(ctrl1_ff[C1_INIT]))
		else $error("pin not loaded with initial level");
	AST_TMR_REL: assert property (@(posedge ref_clk) disable iff (!rstN)
		mode == PTM_MODE_TMR |-> timerPinOeN)
		else $error("pin driven in timer mode");
	AST_FLAG_A: assert property (@(posedge ref_clk) disable iff (!rstN)
		setA |=> flagA_ff)
		else $error("flag A lost");
	COV_CAP: cover property (@(posedge ref_clk) capEdge);
	COV_PULSE: cover property (@(posedge ref_clk) pulseMode && matchA);
	COV_PWMP: cover property (@(posedge ref_clk)
		mode == PTM_MODE_PWM && setP);
endmodule
`default_nettype wire

// File: ptm_pin_partner.sv
// pin partner: drives both timer input pins and loads the output pin
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_partner (
	input  wire logic ref_clk,
	input  wire logic pinReq,
	input  wire logic ckReq,
	input  wire logic timerPinOut,
	input  wire logic timerPinOeN,
	output logic      timerPinIn = 1'b0,
	output logic      timerClockPin = 1'b0,
	output logic      pinSeen
);
	// levels move one edge after the bench asks and then stay put
	always @(posedge ref_clk) begin
		timerPinIn <= pinReq;
		timerClockPin <= ckReq;
	end
	// a released pin sits at its pull-up level
	assign pinSeen = timerPinOeN ? 1'b1 : timerPinOut;
endmodule
`default_nettype wire

// File: ptm_timer_test.sv
// self-checking bench for the periodic timer modes
`timescale 1ns/10ps
`default_nettype none
module ptm_timer_test;
	import ptm_pkg::*;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdData;
	logic [31:0] keep;
	logic        rdErr;
	int          irqs = 0;
	int          irqBase;
	logic        pready, pslverr, timerPinOut, timerPinOeN, timerIrq;
	logic        timerPinIn, timerClockPin, pinSeen;
	logic        pinReq = 1'b0;
	logic        ckReq = 1'b0;
	logic [1:0]  act;
	logic [3:0]  expTbl = 4'b0101;
	int          nErrors = 0;
	int          samplesChecked = 0;
	int          cycles = 0;

	initial forever #4 ref_clk = ~ref_clk;

	ptm_timer DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .timerPinIn(timerPinIn),
		.timerClockPin(timerClockPin), .timerPinOut(timerPinOut),
		.timerPinOeN(timerPinOeN), .timerIrq(timerIrq));
	ptm_pin_partner PARTNER (.ref_clk(ref_clk), .pinReq(pinReq),
		.ckReq(ckReq), .timerPinOut(timerPinOut),
		.timerPinOeN(timerPinOeN), .timerPinIn(timerPinIn),
		.timerClockPin(timerClockPin), .pinSeen(pinSeen));

	task automatic stopTest;
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			nErrors++;
			stopTest;
		end
	end
	// count timer interrupt pulses
	always @(posedge ref_clk) begin
		if (timerIrq === 1'b1) begin
			irqs <= irqs + 1;
		end
	end
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// one apb transfer, setup then access until pready
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		samplesChecked++;
		if (got !== e) begin
			nErrors++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, e);
		end
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rdData, e);
	endtask
	// stop, set mode and both compare values, clear flags
	task automatic cfg(input logic [7:0] c1, input logic [9:0] a,
		input logic [9:0] p);
		wr(ADDR_CTRL0, 32'h0);
		wr(ADDR_CTRL1, {24'h0, c1});
		wr(ADDR_CMPA_LO, {24'h0, a[7:0]});
		wr(ADDR_CMPA_HI, {30'h0, a[9:8]});
		wr(ADDR_PER_LO, {24'h0, p[7:0]});
		wr(ADDR_PER_HI, {30'h0, p[9:8]});
		wr(ADDR_FLAGS, 32'h3);
	endtask
	// count active pin cycles over ten periods of four
	task automatic pwmChk(input logic [7:0] c1, input logic [9:0] a,
		input int e);
		int hi;
		hi = 0;
		cfg(c1, a, 10'd4);
		wr(ADDR_CTRL0, 32'h8);
		idle(8);
		repeat (40) begin
			@(posedge ref_clk);
			hi += (pinSeen === 1'b1);
		end
		chk(32'(hi), 32'(e));
	endtask

	initial begin
		idle(20);
		resetn <= 1'b1;
		idle(3);
		rdChk(ADDR_CTRL1, 32'h0);
		rdChk(ADDR_PER_HI, 32'h0);
		wr(ADDR_PER_HI, 32'hff);
		rdChk(ADDR_PER_HI, 32'h3);
		rdChk(8'h40, 32'h0);
		chk({31'h0, rdErr}, 32'h0);
		// every pin action, initial level high
		for (int i = 0; i < 4; i++) begin
			act = 2'(i);
			cfg({2'b00, act, 4'b1000}, 10'd200, 10'd250);
			wr(ADDR_CTRL0, 32'h8);
			idle(2);
			chk({31'h0, pinSeen}, 32'h1);
			idle(215);
			chk({31'h0, pinSeen}, {31'h0, expTbl[i]});
			idle(60);
			chk({31'h0, pinSeen}, {31'h0, expTbl[i]});
			rdChk(ADDR_FLAGS, 32'h3);
		end
		cfg(8'h21, 10'd20, 10'd5);
		wr(ADDR_CTRL0, 32'h8);
		idle(100);
		rdChk(ADDR_FLAGS, 32'h1);
		cfg(8'hc0, 10'd20, 10'd30);
		wr(ADDR_CTRL0, 32'h8);
		idle(100);
		rdChk(ADDR_FLAGS, 32'h3);
		chk({31'h0, timerPinOeN}, 32'h1);
		pwmChk(8'ha8, 10'd1, 10);
		rdChk(ADDR_FLAGS, 32'h3);
		pwmChk(8'ha8, 10'd7, 40);
		pwmChk(8'hac, 10'd1, 30);
		pwmChk(8'ha0, 10'd1, 30);
		pwmChk(8'h98, 10'd1, 40);
		pwmChk(8'h88, 10'd1, 0);
		cfg(8'hb8, 10'd30, 10'd5);
		irqBase = irqs;
		ckReq <= 1'b1;
		idle(6);
		rdChk(ADDR_CTRL0, 32'h8);
		chk({31'h0, pinSeen}, 32'h1);
		idle(40);
		rdChk(ADDR_CTRL0, 32'h0);
		chk({31'h0, pinSeen}, 32'h0);
		rdChk(ADDR_FLAGS, 32'h1);
		chk(32'(irqs - irqBase), 32'h1);
		apb(ADDR_CNT_LO, 1'b0, 32'h0);
		keep = rdData;
		idle(20);
		rdChk(ADDR_CNT_LO, keep);
		cfg(8'h40, 10'd0, 10'd0);
		wr(ADDR_CTRL0, 32'h8);
		idle(50);
		pinReq <= 1'b1;
		idle(6);
		rdChk(ADDR_FLAGS, 32'h1);
		apb(ADDR_CMPA_LO, 1'b0, 32'h0);
		chk({31'h0, rdData !== 32'h0}, 32'h1);
		wr(ADDR_FLAGS, 32'h3);
		pinReq <= 1'b0;
		idle(6);
		rdChk(ADDR_FLAGS, 32'h0);
		cfg(8'h62, 10'd0, 10'd0);
		wr(ADDR_CTRL0, 32'h8);
		idle(20);
		ckReq <= 1'b0;
		idle(6);
		rdChk(ADDR_FLAGS, 32'h1);
		cfg(8'h70, 10'd0, 10'd0);
		wr(ADDR_CTRL0, 32'h8);
		pinReq <= 1'b1;
		idle(6);
		rdChk(ADDR_CMPA_LO, 32'h0);
		rdChk(ADDR_FLAGS, 32'h0);
		stopTest;
	end
endmodule
`default_nettype wire
